//--- rtl/spc_pkg.sv
// Package for the serial port control block: register map, field layout, timing counts.
// Assumes one 20 MHz clock and an AHB-Lite master with single word transfers.
package spc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_SETUP = 8'h00;
  localparam logic [7:0] ADDR_SLOT = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // ==========================================================
  // Setup register field positions
  localparam int F_INPUT_WORD_LENGTH = 0;
  localparam int F_OUTPUT_WORD_LENGTH = 1;
  localparam int F_ICK = 2;
  localparam int F_OCK = 3;
  localparam int F_ILD = 4;
  localparam int F_OLD = 5;
  localparam int F_MSB = 6;
  localparam int F_CLK_LO = 7;
  localparam int F_SYNC_SRC = 9;
  localparam int SETUP_W = 10;
  localparam logic [9:0] SETUP_RST = 10'h000;
  localparam int F_RATE = 9;
  // ==========================================================
  // Timing counts
  localparam logic [4:0] DIV_HALF_0 = 5'h02;
  localparam logic [4:0] DIV_HALF_1 = 5'h06;
  localparam logic [4:0] DIV_HALF_2 = 5'h08;
  localparam logic [4:0] DIV_HALF_3 = 5'h0a;
  localparam logic [3:0] LOAD_PERIOD_M1 = 4'hf;
  localparam logic [7:0] SYNC_128_M1 = 8'h7f;
  localparam logic [7:0] SYNC_256_M1 = 8'hff;
  localparam logic [4:0] LEN16 = 5'h10;
  localparam logic [4:0] LEN8 = 5'h08;
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 16;
  // ==========================================================
  // Bundled types
  typedef struct packed {
    logic ick_o;
    logic ick_oe_n;
    logic ock_o;
    logic ock_oe_n;
    logic ild_o;
    logic ild_oe_n;
    logic old_o;
    logic old_oe_n;
    logic sync_o;
    logic sdo;
  } spc_pins_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
  } spc_ahb_rsp_t;
endpackage : spc_pkg

//--- rtl/spc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and asynchronous active high reset.
`timescale 1ns/10ps
module spc_fifo
  import spc_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } spc_fifo_st_t;
  spc_fifo_st_t st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  // ==========================================================
  // Flags and handshakes
  assign in_ready = (st.cnt != DEPTH[AW:0]);
  assign out_valid = (st.cnt != '0);
  assign out_data = mem[st.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Pointer and count update
  always_comb
  begin
    next_st = st;
    if (push) next_st.wp = st.wp + 1'b1;
    if (pop) next_st.rp = st.rp + 1'b1;
    if (push && !pop) next_st.cnt = st.cnt + 1'b1;
    else if (pop && !push) next_st.cnt = st.cnt - 1'b1;
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst) st <= '0;
    else st <= next_st;
  end
  // Storage write
  always_ff @(posedge clock)
  begin
    if (push) mem[st.wp] <= in_data;
  end
endmodule : spc_fifo

//--- rtl/spc_serial_port.sv
// Serial port control: setup register, bit clock divider, pin directions, shifters.
// Assumes pins from the far side are synchronous to clock; clock is the master clock input.
`timescale 1ns/10ps
// Overview of operation
// - Setup bit 5 makes output strobe driven
// - Setup bit 4 makes input strobe driven
// - Setup bit 3 makes output clock driven
// - Setup bit 2 makes input clock driven
// - Frame sync every 128 or 256 bit clocks
module spc_serial_port
  import spc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic input_bit_clock_i,
  input wire logic output_bit_clock_i,
  input wire logic input_load_strobe_i,
  input wire logic output_load_strobe_i,
  input wire logic sdi,
  output logic input_bit_clock_o,
  output logic input_bit_clock_oe_n,
  output logic output_bit_clock_o,
  output logic output_bit_clock_oe_n,
  output logic input_load_strobe_o,
  output logic input_load_strobe_oe_n,
  output logic output_load_strobe_o,
  output logic output_load_strobe_oe_n,
  output logic frame_sync,
  output logic sdo
);
  typedef struct packed {
    logic [SETUP_W-1:0] setup;
    logic [SETUP_W-1:0] slot;
    logic wr_pend;
    logic [7:0] wr_addr;
    spc_ahb_rsp_t rsp;
    logic [4:0] div;
    logic gen_clk;
    logic [3:0] ld_cnt;
    logic [7:0] sync_cnt;
    spc_pins_t pins;
    logic ick_q;
    logic ock_q;
    logic old_q;
    logic [15:0] rx_sh;
    logic [4:0] rx_cnt;
    logic [15:0] rx_word;
    logic rx_ovf;
    logic [15:0] tx_sh;
    logic [4:0] tx_cnt;
  } spc_st_t;
  spc_st_t st, next_st;
  logic [4:0] half;
  logic input_bit_clock, output_bit_clock, input_load_strobe, old, ick_rise, ock_rise, ock_fall;
  logic in_len8, out_len8, msb_first;
  logic [4:0] in_len, out_len;
  logic tx_fifo_valid, tx_fifo_ready, tx_pop;
  logic [15:0] tx_fifo_data;
  // ==========================================================
  // Transmit data FIFO
  spc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_txq (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(st.wr_pend && st.wr_addr == ADDR_TXDATA),
    .in_ready(tx_fifo_ready),
    .in_data(hwdata[15:0]),
    .out_valid(tx_fifo_valid),
    .out_ready(tx_pop),
    .out_data(tx_fifo_data)
  );
  // ==========================================================
  // Effective pin levels: own generated signals or far-side inputs
  always_comb
  begin
    case (st.setup[F_CLK_LO+1:F_CLK_LO])
      2'b00: half = DIV_HALF_0;
      2'b01: half = DIV_HALF_1;
      2'b10: half = DIV_HALF_2;
      default: half = DIV_HALF_3;
    endcase
  end
  assign input_bit_clock = st.setup[F_ICK] ? st.gen_clk : input_bit_clock_i;
  assign output_bit_clock = st.setup[F_OCK] ? st.gen_clk : output_bit_clock_i;
  assign input_load_strobe = st.setup[F_ILD] ? st.pins.ild_o : input_load_strobe_i;
  assign old = st.setup[F_OLD] ? st.pins.old_o : output_load_strobe_i;
  assign ick_rise = input_bit_clock && !st.ick_q;
  assign ock_rise = output_bit_clock && !st.ock_q;
  assign ock_fall = !output_bit_clock && st.ock_q;
  assign in_len8 = st.setup[F_INPUT_WORD_LENGTH];
  assign out_len8 = st.setup[F_OUTPUT_WORD_LENGTH];
  assign msb_first = st.setup[F_MSB];
  assign in_len = in_len8 ? LEN8 : LEN16;
  assign out_len = out_len8 ? LEN8 : LEN16;
  // Load on the strobe's rising level: an own strobe lags the clock edge by one cycle
  assign tx_pop = old && !st.old_q && (st.tx_cnt == 5'h00) && tx_fifo_valid;
  // ==========================================================
  // Next state
  always_comb
  begin
    next_st = st;
    // AHB-Lite slave: address phase capture, zero wait data phase
    next_st.wr_pend = 1'b0;
    next_st.rsp.hreadyout = 1'b1;
    if (hsel && hready && htrans[1])
    begin
      next_st.wr_pend = hwrite;
      next_st.wr_addr = haddr[7:0];
      next_st.rsp.hrdata = 32'h0000_0000;
      if (!hwrite)
      begin
        case (haddr[7:0])
          ADDR_SETUP: next_st.rsp.hrdata = {22'h000000, st.setup};
          ADDR_SLOT: next_st.rsp.hrdata = {22'h000000, st.slot};
          ADDR_RXDATA: next_st.rsp.hrdata = {16'h0000, st.rx_word};
          ADDR_STATUS: next_st.rsp.hrdata = {29'h00000000, st.rx_ovf,
            tx_fifo_valid, tx_fifo_ready};
          default: next_st.rsp.hrdata = 32'h0000_0000;
        endcase
        if (haddr[7:0] == ADDR_RXDATA) next_st.rx_ovf = 1'b0;
      end
    end
    if (st.wr_pend)
    begin
      case (st.wr_addr)
        ADDR_SETUP: next_st.setup = hwdata[SETUP_W-1:0];
        ADDR_SLOT: next_st.slot = hwdata[SETUP_W-1:0];
        default: ;
      endcase
    end
    // Bit clock divider, half period per selected code
    if (st.div >= half - 5'h01)
    begin
      next_st.div = 5'h00;
      next_st.gen_clk = !st.gen_clk;
    end
    else next_st.div = st.div + 5'h01;
    // Load strobe every 16 bit clocks, frame sync every 128 or 256
    next_st.pins.ild_o = 1'b0;
    next_st.pins.old_o = 1'b0;
    next_st.pins.sync_o = 1'b0;
    if ((st.setup[F_SYNC_SRC] ? ock_rise : ick_rise))
    begin
      next_st.ld_cnt = st.ld_cnt + 4'h1;
      next_st.sync_cnt = st.sync_cnt + 8'h01;
      if (st.ld_cnt == LOAD_PERIOD_M1)
      begin
        next_st.pins.ild_o = st.setup[F_ILD];
        next_st.pins.old_o = st.setup[F_OLD];
      end
      if (st.sync_cnt == (st.slot[F_RATE] ? SYNC_256_M1 : SYNC_128_M1))
      begin
        next_st.sync_cnt = 8'h00;
        next_st.pins.sync_o = 1'b1;
      end
      if (!st.slot[F_RATE] && st.sync_cnt[7]) next_st.sync_cnt = 8'h00;
    end
    // Pin drive and enables (low enable drives the pin)
    next_st.pins.ick_o = st.gen_clk;
    next_st.pins.ock_o = st.gen_clk;
    next_st.pins.ick_oe_n = !st.setup[F_ICK];
    next_st.pins.ock_oe_n = !st.setup[F_OCK];
    next_st.pins.ild_oe_n = !st.setup[F_ILD];
    next_st.pins.old_oe_n = !st.setup[F_OLD];
    next_st.ick_q = input_bit_clock;
    next_st.ock_q = output_bit_clock;
    next_st.old_q = old;
    // Receive shifter on input bit clock rising edge
    if (ick_rise)
    begin
      if (input_load_strobe && st.rx_cnt == 5'h00) next_st.rx_cnt = in_len;
      if (st.rx_cnt != 5'h00 || input_load_strobe)
      begin
        if (msb_first) next_st.rx_sh = {st.rx_sh[14:0], sdi};
        else if (in_len8) next_st.rx_sh = {8'h00, sdi, st.rx_sh[7:1]};
        else next_st.rx_sh = {sdi, st.rx_sh[15:1]};
        if (st.rx_cnt == 5'h01)
        begin
          next_st.rx_word = msb_first && in_len8 ? {8'h00, st.rx_sh[6:0], sdi}
            : (msb_first ? {st.rx_sh[14:0], sdi} : next_st.rx_sh);
          next_st.rx_ovf = st.rx_ovf | 1'b1;
          next_st.rx_cnt = 5'h00;
        end
        else if (st.rx_cnt != 5'h00) next_st.rx_cnt = st.rx_cnt - 5'h01;
      end
    end
    // Transmit shifter loads on strobe, shifts out on falling output clock
    if (tx_pop)
    begin
      next_st.tx_sh = tx_fifo_data;
      next_st.tx_cnt = out_len;
    end
    if (ock_fall && st.tx_cnt != 5'h00)
    begin
      next_st.pins.sdo = msb_first ? st.tx_sh[out_len8 ? 7 : 15] : st.tx_sh[0];
      next_st.tx_sh = msb_first ? {st.tx_sh[14:0], 1'b0} : {1'b0, st.tx_sh[15:1]};
      next_st.tx_cnt = st.tx_cnt - 5'h01;
    end
  end
  // ==========================================================
  // State register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.setup <= SETUP_RST;
      st.rsp.hreadyout <= 1'b1;
      st.pins.ick_oe_n <= 1'b1;
      st.pins.ock_oe_n <= 1'b1;
      st.pins.ild_oe_n <= 1'b1;
      st.pins.old_oe_n <= 1'b1;
    end
    else st <= next_st;
  end
  // ==========================================================
  // Outputs straight from flip-flops, except hresp which is tied low
  assign hrdata = st.rsp.hrdata;
  assign hreadyout = st.rsp.hreadyout;
  assign hresp = 1'b0;
  assign input_bit_clock_o = st.pins.ick_o;
  assign input_bit_clock_oe_n = st.pins.ick_oe_n;
  assign output_bit_clock_o = st.pins.ock_o;
  assign output_bit_clock_oe_n = st.pins.ock_oe_n;
  assign input_load_strobe_o = st.pins.ild_o;
  assign input_load_strobe_oe_n = st.pins.ild_oe_n;
  assign output_load_strobe_o = st.pins.old_o;
  assign output_load_strobe_oe_n = st.pins.old_oe_n;
  assign frame_sync = st.pins.sync_o;
  assign sdo = st.pins.sdo;
endmodule : spc_serial_port

//--- verification/spc_serial_port_sva.sv
// Checker for the serial port control block: pin directions, bit clock, frame sync, bus.
// Assumes it is bound to spc_serial_port and sees only that module's ports.
`timescale 1ns/10ps
module spc_serial_port_sva
  import spc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic input_bit_clock_i,
  input wire logic output_bit_clock_i,
  input wire logic input_bit_clock_o,
  input wire logic input_bit_clock_oe_n,
  input wire logic output_bit_clock_o,
  input wire logic output_bit_clock_oe_n,
  input wire logic input_load_strobe_oe_n,
  input wire logic output_load_strobe_oe_n,
  input wire logic frame_sync,
  input wire logic sdo
);
  logic wpend, ick_q, src_q, fs_ok, rate, src, ock_res;
  logic [7:0] wa, settle, run;
  logic [8:0] rises, per;
  logic [9:0] setup;
  logic [4:0] half;
  // ========
  // Mirror of the setup and slot registers, cycle and edge counters
  assign ock_res = output_bit_clock_oe_n ? output_bit_clock_i : output_bit_clock_o;
  assign src = setup[F_SYNC_SRC] ? ock_res :
    (input_bit_clock_oe_n ? input_bit_clock_i : input_bit_clock_o);
  assign per = rate ? 9'h100 : 9'h080;
  assign half = setup[8] ? (setup[7] ? 5'h0a : 5'h08) : (setup[7] ? 5'h06 : 5'h02);
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      setup <= SETUP_RST;
      rate <= 1'b0;
      settle <= 8'h00;
      fs_ok <= 1'b0;
      wpend <= 1'b0;
    end
    else
    begin
      wpend <= hsel && hready && htrans[1] && hwrite;
      settle <= settle + {7'h0, settle != 8'hff};
      if (frame_sync)
        fs_ok <= 1'b1;
      if (wpend && (wa == ADDR_SETUP || wa == ADDR_SLOT))
      begin
        settle <= 8'h00;
        fs_ok <= 1'b0;
        if (wa == ADDR_SETUP)
          setup <= hwdata[SETUP_W-1:0];
        else
          rate <= hwdata[F_RATE];
      end
    end
  end
  always_ff @(posedge clock)
  begin
    wa <= haddr[7:0];
    ick_q <= input_bit_clock_o;
    src_q <= src;
    run <= (input_bit_clock_o != ick_q) ? 8'h01 : run + {7'h0, run != 8'hff};
    rises <= frame_sync ? 9'h000 : rises + {8'h0, src && !src_q};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ========
  // Assertions
  a_old_dir: assert property (settle > 8'h02 |-> output_load_strobe_oe_n == !setup[F_OLD])
    else $error("output strobe direction wrong");
  a_ild_dir: assert property (settle > 8'h02 |-> input_load_strobe_oe_n == !setup[F_ILD])
    else $error("input strobe direction wrong");
  a_ock_dir: assert property (settle > 8'h02 |-> output_bit_clock_oe_n == !setup[F_OCK])
    else $error("output clock direction wrong");
  a_ick_dir: assert property (settle > 8'h02 |-> input_bit_clock_oe_n == !setup[F_ICK])
    else $error("input clock direction wrong");
  a_clk_divide: assert property (setup[F_ICK] && settle > 8'd40 && $changed(input_bit_clock_o)
    |-> run == {3'h0, half}) else $error("bit clock half period wrong");
  a_sync_period: assert property (frame_sync && fs_ok |-> rises >= per - 9'h1 && rises <= per + 9'h1)
    else $error("frame sync period wrong");
  a_sdo_at_rise: assert property ($rose(ock_res) && settle > 8'h04 |-> $stable(sdo))
    else $error("serial data moved at sampling edge");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  c_sync: cover property (frame_sync && fs_ok);
  c_div: cover property (setup[F_ICK] && settle > 8'd40 && $changed(input_bit_clock_o));
  c_tx: cover property ($rose(ock_res) && !output_bit_clock_oe_n);
endmodule : spc_serial_port_sva
bind spc_serial_port spc_serial_port_sva spc_serial_port_sva_inst (.*);

//--- verification/spc_codec.sv
// Far-side serial device: supplies passive bit clocks and strobes, records sent bits.
// Assumes the bench resolves every pin and feeds back the wire level.
`timescale 1ns/10ps
module spc_codec #(
  parameter int HALF = 3
)(
  input wire logic clock,
  input wire logic run,
  input wire logic output_bit_clock,
  input wire logic sdo,
  output logic clk_i = 1'b0,
  output logic strobe_i = 1'b0,
  output logic sdi = 1'b0,
  output logic [63:0] hist = '0
);
  logic [7:0] cnt = 8'h00;
  logic [3:0] nb = 4'h0;
  logic oq = 1'b0;
  // ========
  // Clock and strobe generation, capture of sent bits
  always @(posedge clock)
  begin
    oq <= output_bit_clock;
    sdi <= ~sdi; // Changes every cycle, never a stale level
    strobe_i <= 1'b0;
    if (output_bit_clock && !oq)
      hist <= {hist[62:0], sdo};
    if (!run)
    begin
      cnt <= 8'h00;
      clk_i <= 1'b0; // Clock stands still while run is low
    end
    else if (cnt == 8'(HALF - 1))
    begin
      cnt <= 8'h00;
      clk_i <= ~clk_i;
      nb <= nb + 4'(!clk_i);
      strobe_i <= !clk_i && nb == 4'hf; // Strobe every 16 bit clocks
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule : spc_codec

//--- verification/testbench.sv
// Self-checking bench for the serial port control block.
// Assumes one 20 MHz clock and a zero wait state bus slave.
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
module testbench;
  import spc_pkg::*;
  logic clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp, sdi, sdo, frame_sync;
  logic p_clk, p_stb, run, input_bit_clock_i, output_bit_clock_i;
  logic input_load_strobe_i, output_load_strobe_i, input_bit_clock_o, input_bit_clock_oe_n;
  logic output_bit_clock_o, output_bit_clock_oe_n, input_load_strobe_o, input_load_strobe_oe_n;
  logic output_load_strobe_o, output_load_strobe_oe_n;
  logic [31:0] haddr, hwdata, hrdata, q, pat, msk;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [63:0] hist;
  int num_errors, comparisons, cyc, n;
  int dv[4] = '{4, 12, 16, 20};
  logic [15:0] wd[4] = '{16'h1c35, 16'h6b19, 16'h0e4d, 16'h72a3};
  // ========
  // Wire levels: the far side drives a pin only while the block leaves it passive
  assign hready = hreadyout;
  assign input_bit_clock_i = input_bit_clock_oe_n ? p_clk : input_bit_clock_o;
  assign output_bit_clock_i = output_bit_clock_oe_n ? p_clk : output_bit_clock_o;
  assign input_load_strobe_i = input_load_strobe_oe_n ? p_stb : input_load_strobe_o;
  assign output_load_strobe_i = output_load_strobe_oe_n ? p_stb : output_load_strobe_o;
  spc_serial_port spc_serial_port_inst (.*);
  spc_codec spc_codec_inst (.clock(clock), .run(run), .output_bit_clock(output_bit_clock_i), .sdo(sdo),
    .clk_i(p_clk), .strobe_i(p_stb), .sdi(sdi), .hist(hist));
  always #25 clock = ~clock;
  // Hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      conclude();
    end
  end
  // ========
  // Tasks
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic t_regs;
    xfer(ADDR_SETUP, 1'b0, 32'h0);
    `CHK("setup_reset", {22'h0, SETUP_RST}, q)
    xfer(ADDR_SETUP, 1'b1, 32'h3ff);
    xfer(ADDR_SETUP, 1'b0, 32'h0);
    `CHK("setup_rw", 32'h3ff, q)
    xfer(8'h20, 1'b1, 32'hffff);
    xfer(8'h20, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, q)
  endtask : t_regs
  task automatic t_dirs;
    for (int i = 0; i < 16; i++)
    begin
      xfer(ADDR_SETUP, 1'b1, 32'(i << 2));
      repeat (3) @(posedge clock);
      #1;
      `CHK("old_dir", !i[3], output_load_strobe_oe_n)
      `CHK("ild_dir", !i[2], input_load_strobe_oe_n)
      `CHK("ock_dir", !i[1], output_bit_clock_oe_n)
      `CHK("ick_dir", !i[0], input_bit_clock_oe_n)
      @(posedge clock);
    end
  endtask : t_dirs
  task automatic t_div;
    for (int c = 0; c < 4; c++)
    begin
      xfer(ADDR_SETUP, 1'b1, 32'((c << 7) | 4));
      repeat (50) @(negedge clock);
      while (input_bit_clock_o !== 1'b0) @(negedge clock);
      while (input_bit_clock_o !== 1'b1) @(negedge clock);
      for (n = 0; input_bit_clock_o === 1'b1; n++) @(negedge clock);
      `CHK("half_period", dv[c] / 2, n)
      @(posedge clock);
    end
  endtask : t_div
  task automatic t_sync;
    for (int r = 0; r < 2; r++)
    begin
      xfer(ADDR_SLOT, 1'b1, 32'(r << 9));
      xfer(ADDR_SETUP, 1'b1, 32'h4);
      while (frame_sync !== 1'b1) @(negedge clock);
      @(negedge clock);
      for (n = 1; frame_sync !== 1'b1; n++) @(negedge clock);
      `CHK("sync_gap", (r ? 256 : 128) * 4, n)
      @(posedge clock);
    end
  endtask : t_sync
  task automatic t_tx;
    for (int k = 0; k < 4; k++)
    begin
      xfer(ADDR_SETUP, 1'b1, 32'h228 | 32'(k[0] << 6) | 32'(k[1] << 1));
      xfer(ADDR_TXDATA, 1'b1, {16'h0, wd[k]});
      do xfer(ADDR_STATUS, 1'b0, 32'h0); while (q[1] !== 1'b0);
      repeat (80) @(posedge clock);
      n = k[1] ? 8 : 16;
      pat = 32'h0;
      for (int j = 0; j < n; j++)
        pat[n - 1 - j] = k[0] ? wd[k][n - 1 - j] : wd[k][j];
      msk = (32'h1 << n) - 32'h1;
      q = 32'h0;
      for (int p = 0; p <= 64 - n; p++)
        q[0] = q[0] | ((32'(hist >> p) & msk) === pat);
      `CHK("tx_bits", 1'b1, q[0])
    end
  endtask : t_tx
  task automatic t_fifo;
    xfer(ADDR_SETUP, 1'b0 + 1'b1, 32'h0);
    for (int i = 0; i < 17; i++)
      xfer(ADDR_TXDATA, 1'b1, 32'(i));
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    `CHK("fifo_full", 2'b10, q[1:0])
    run <= 1'b1;
    do xfer(ADDR_STATUS, 1'b0, 32'h0); while (q[1] !== 1'b0);
    `CHK("fifo_empty", 2'b01, q[1:0])
    run <= 1'b0;
  endtask : t_fifo
  // ========
  // Main sequence
  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    run = 1'b0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_dirs();
    t_div();
    t_sync();
    t_tx();
    t_fifo();
    conclude();
  end
endmodule : testbench
